// File: dvp_pkg.sv
// Shared constants and types for the distance value post-processor.
package dvp_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int unsigned DW   = 16;  // Distance sample width.
  localparam int unsigned CW   = 7;   // Sample count width.
  localparam int unsigned SUMW = 23;  // Sum of up to 99 samples.
  localparam int unsigned OW   = 18;  // Signed offset width.
  localparam int unsigned RW   = 19;  // Signed result width.
  localparam int unsigned MAXN = 99;  // Deepest history kept.

  // ---------------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------------
  localparam logic [CW-1:0] AVG_N_DEF   = 7'h0A;  // Ten samples.
  localparam logic [CW-1:0] AVG_N_MIN   = 7'h02;
  localparam logic [CW-1:0] SPIKE_N_MIN = 7'h05;
  localparam logic [CW-1:0] N_MAX       = 7'h63;  // 99 samples.

  // ---------------------------------------------------------------------
  // Trim fractions per side, in percent
  // ---------------------------------------------------------------------
  localparam logic [6:0] PCT_COARSE  = 7'h0C;  // 12 %.
  localparam logic [6:0] PCT_MEDIUM  = 7'h18;  // 24 %.
  localparam logic [6:0] PCT_STRONG  = 7'h24;  // 36 %.
  localparam logic [6:0] PCT_FULL    = 7'h64;  // 100 %.
  localparam logic [4:0] DIV_STEPS   = 5'h17;  // One step per sum bit.

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    DVP_FILT_NONE,
    DVP_FILT_AVG,
    DVP_FILT_SPIKE
  } dvp_filter_t;

  typedef enum logic [1:0] {
    DVP_DEPTH_COARSE,
    DVP_DEPTH_MEDIUM,
    DVP_DEPTH_STRONG
  } dvp_depth_t;

  typedef enum logic [1:0] {
    DVP_IDLE,
    DVP_SUM,
    DVP_DIV,
    DVP_POST
  } dvp_state_t;

endpackage : dvp_pkg

// File: dvp_div_if.sv
// Request and answer signals between the pipeline and its divider.
interface dvp_div_if;
  import dvp_pkg::*;

  logic            start;
  logic [SUMW-1:0] dividend;
  logic [CW-1:0]   divisor;
  logic            done;
  logic [SUMW-1:0] quotient;

  modport requester (output start, output dividend, output divisor,
                     input done, input quotient);
  modport divider   (input start, input dividend, input divisor,
                     output done, output quotient);
endinterface : dvp_div_if

// File: dvp_divider.sv
// Iterative restoring divider for the mean of the selected samples.
module dvp_divider
  import dvp_pkg::*;
(
  input  wire logic clk_i,    // Processing clock.
  input  wire logic rst_n_i,  // Asynchronous reset, active low.
  dvp_div_if.divider div      // Division request and answer.
);

  logic [SUMW-1:0] quo_reg;
  logic [CW:0]     rem_reg;
  logic [4:0]      step_reg;
  logic            busy_reg;
  logic            done_reg;

  wire  [CW:0]     rem_shift = {rem_reg[CW-1:0], quo_reg[SUMW-1]};
  wire             fits      = rem_shift >= {1'b0, div.divisor};

  assign div.done     = done_reg;
  assign div.quotient = quo_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quo_reg  <= '0;
      rem_reg  <= '0;
      step_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (div.start) begin
      quo_reg  <= div.dividend;
      rem_reg  <= '0;
      step_reg <= DIV_STEPS;
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg) begin
      quo_reg  <= {quo_reg[SUMW-2:0], fits};
      rem_reg  <= fits ? rem_shift - {1'b0, div.divisor} : rem_shift;
      step_reg <= step_reg - 5'h01;
      busy_reg <= step_reg != 5'h01;
      done_reg <= step_reg == 5'h01;
    end else begin
      done_reg <= 1'b0;
    end
  end

endmodule : dvp_divider

// File: dvp_postproc.sv
// Distance post-processor: filter, slope, offset, preset capture, clamp.
//
// Overview of operation
// - Averaging mode outputs the mean of the latest configured samples.
// - A step in input ramps linearly over exactly the window length.
// - Exactly one result is emitted for every accepted sample.
// - Outlier suppression gathers a full block, then evaluates it whole.
// - Coarse depth drops 12 % per side, averages central 76 %.
// - Medium depth drops 24 % per side, averages central 52 %.
// - Strong depth drops 36 % per side, averages central 28 %.
// - Falling slope negates the filtered distance; it may go negative.
// - The signed offset is added before the result is presented.
// - Capture sets offset to nominal preset minus current measured value.
// - A negative corrected result is presented as zero.
// - Filter choices are none (reset default), averaging, or suppression.
// - Averaging window is configurable and resets to ten samples.
// - Suppression block length is configurable from five to 99.
module dvp_postproc
  import dvp_pkg::*;
(
  input  wire logic          clk_i,           // Processing clock.
  input  wire logic          rst_n_i,         // Async reset, active low.
  input  wire logic          sample_valid_i,  // New distance sample.
  input  wire logic [DW-1:0] sample_i,        // Raw distance.
  output logic               sample_ready_o,  // Pipeline can take a sample.
  input  wire logic          cfg_wr_i,        // Load filter settings.
  input  wire logic [1:0]    cfg_filter_i,    // Filter selection.
  input  wire logic [CW-1:0] cfg_count_i,     // Window or block length.
  input  wire logic [1:0]    cfg_depth_i,     // Suppression depth.
  input  wire logic          cfg_falling_i,   // Falling output slope.
  input  wire logic          offset_wr_i,     // Load offset directly.
  input  wire logic [OW-1:0] offset_i,        // Signed offset value.
  input  wire logic [DW-1:0] preset_i,        // Nominal preset distance.
  input  wire logic          reference_capture_trigger_i, // Capture pulse.
  output logic [OW-1:0]      offset_o,        // Offset in use.
  output logic               capture_busy_o,  // Capture pending.
  output logic               result_valid_o,  // One-cycle result strobe.
  output logic [DW-1:0]      result_o         // Clamped distance.
);

  dvp_div_if div ();

  dvp_divider u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .div     (div.divider)
  );

  // -----------------------------------------------------------------------
  // Configuration and state
  // -----------------------------------------------------------------------
  dvp_state_t      state_reg;
  dvp_filter_t     filt_reg;
  dvp_depth_t      depth_reg;
  logic [CW-1:0]   count_reg;
  logic [OW-1:0]   offset_reg;
  logic            cap_pend_reg;
  logic [DW-1:0]   hist_reg [MAXN];
  logic [CW-1:0]   fill_reg;
  logic [CW-1:0]   blk_reg;
  logic [DW-1:0]   filt_out_reg;
  logic [DW-1:0]   spike_hold_reg;
  logic            spike_ok_reg;
  logic [RW-1:0]   meas_reg;
  logic            res_valid_reg;
  logic [DW-1:0]   res_reg;

  // -----------------------------------------------------------------------
  // Window sizing
  // -----------------------------------------------------------------------
  wire [CW-1:0] avg_n = (count_reg < AVG_N_MIN) ? AVG_N_MIN :
                        (count_reg > N_MAX) ? N_MAX : count_reg;
  wire [CW-1:0] spk_n = (count_reg < SPIKE_N_MIN) ? SPIKE_N_MIN :
                        (count_reg > N_MAX) ? N_MAX : count_reg;
  // Until the history is full the mean uses what has arrived so far.
  wire [CW-1:0] avg_used = (fill_reg < avg_n) ? fill_reg : avg_n;
  wire [6:0]    pct = (depth_reg == DVP_DEPTH_STRONG) ? PCT_STRONG :
                      (depth_reg == DVP_DEPTH_MEDIUM) ? PCT_MEDIUM :
                      PCT_COARSE;
  wire [13:0]   trim_prod = 14'(spk_n) * 14'(pct);
  wire [CW-1:0] trim_lo  = CW'(trim_prod / 14'(PCT_FULL));
  wire [CW-1:0] keep_hi  = spk_n - trim_lo;
  wire [CW-1:0] keep_n   = keep_hi - trim_lo;
  wire          blk_full = blk_reg == spk_n;

  // -----------------------------------------------------------------------
  // Per-entry sums and ranks
  // -----------------------------------------------------------------------
  // Ranking by pairwise comparison avoids a sorting network; ties are
  // broken by position so every rank within the block is distinct.
  logic [SUMW-1:0] avg_term [MAXN];
  logic [SUMW-1:0] spk_term [MAXN];
  logic [CW-1:0]   rank     [MAXN];

  genvar gi;
  generate
    for (gi = 0; gi < MAXN; gi++) begin : g_entry
      always_comb begin
        rank[gi] = '0;
        for (int j = 0; j < MAXN; j++) begin
          if (CW'(j) < spk_n && (hist_reg[j] < hist_reg[gi] ||
              (hist_reg[j] == hist_reg[gi] && j < gi)))
            rank[gi] = rank[gi] + 7'h01;
        end
      end
      assign avg_term[gi] = (CW'(gi) < avg_used) ?
                            SUMW'(hist_reg[gi]) : '0;
      assign spk_term[gi] = (CW'(gi) < spk_n && rank[gi] >= trim_lo &&
                             rank[gi] < keep_hi) ?
                            SUMW'(hist_reg[gi]) : '0;
    end
  endgenerate

  logic [SUMW-1:0] avg_sum;
  logic [SUMW-1:0] spk_sum;
  always_comb begin
    avg_sum = '0;
    spk_sum = '0;
    for (int k = 0; k < MAXN; k++) begin
      avg_sum = avg_sum + avg_term[k];
      spk_sum = spk_sum + spk_term[k];
    end
  end

  // -----------------------------------------------------------------------
  // Divider request
  // -----------------------------------------------------------------------
  wire do_avg   = filt_reg == DVP_FILT_AVG;
  wire do_spike = filt_reg == DVP_FILT_SPIKE && blk_full;
  wire in_sum   = state_reg == DVP_SUM;

  assign div.start    = in_sum && (do_avg || do_spike);
  assign div.dividend = do_avg ? avg_sum : spk_sum;
  assign div.divisor  = do_avg ? avg_used : keep_n;

  wire [DW-1:0] bypass_val = (filt_reg == DVP_FILT_SPIKE && spike_ok_reg) ?
                             spike_hold_reg : hist_reg[0];

  // -----------------------------------------------------------------------
  // Slope, offset and clamp
  // -----------------------------------------------------------------------
  wire [RW-1:0] filt_ext = {{(RW-DW){1'b0}}, filt_out_reg};
  wire [RW-1:0] meas_next = cfg_falling_i ? -filt_ext : filt_ext;
  wire [RW-1:0] post_sum = meas_reg + {offset_reg[OW-1], offset_reg};
  wire          post_neg = post_sum[RW-1];
  wire [DW-1:0] clamp_val = post_neg ? '0 : post_sum[DW-1:0];
  wire [OW-1:0] cap_off = OW'({{(RW-DW){1'b0}}, preset_i} - meas_reg);

  assign sample_ready_o = state_reg == DVP_IDLE;
  assign offset_o       = offset_reg;
  assign capture_busy_o = cap_pend_reg;
  assign result_valid_o = res_valid_reg;
  assign result_o       = res_reg;

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= DVP_IDLE;
    end else begin
      unique case (state_reg)
        DVP_IDLE: if (sample_valid_i) state_reg <= DVP_SUM;
        DVP_SUM:  state_reg <= div.start ? DVP_DIV : DVP_POST;
        DVP_DIV:  if (div.done) state_reg <= DVP_POST;
        DVP_POST: state_reg <= DVP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_reg  <= DVP_FILT_NONE;
      count_reg <= AVG_N_DEF;
      depth_reg <= DVP_DEPTH_COARSE;
    end else if (cfg_wr_i) begin
      filt_reg  <= dvp_filter_t'(cfg_filter_i);
      count_reg <= cfg_count_i;
      depth_reg <= dvp_depth_t'(cfg_depth_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sample_valid_i && sample_ready_o) begin
      hist_reg[0] <= sample_i;
      for (int k = 1; k < MAXN; k++) hist_reg[k] <= hist_reg[k-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_reg <= '0;
      blk_reg  <= '0;
    end else if (cfg_wr_i) begin
      fill_reg <= '0;
      blk_reg  <= '0;
    end else if (sample_valid_i && sample_ready_o) begin
      fill_reg <= (fill_reg == N_MAX) ? N_MAX : fill_reg + 7'h01;
      blk_reg  <= blk_reg + 7'h01;
    end else if (do_spike && in_sum) begin
      blk_reg  <= '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_out_reg   <= '0;
      spike_hold_reg <= '0;
      spike_ok_reg   <= 1'b0;
    end else if (in_sum && !div.start) begin
      filt_out_reg   <= bypass_val;
    end else if (div.done) begin
      filt_out_reg   <= div.quotient[DW-1:0];
      if (filt_reg == DVP_FILT_SPIKE) begin
        spike_hold_reg <= div.quotient[DW-1:0];
        spike_ok_reg   <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meas_reg      <= '0;
      res_valid_reg <= 1'b0;
      res_reg       <= '0;
    end else begin
      res_valid_reg <= state_reg == DVP_POST;
      if (state_reg == DVP_POST) meas_reg <= meas_next;
      if (res_valid_reg) res_reg <= clamp_val;
    end
  end

  // A capture arriving with a direct offset write takes priority.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset_reg   <= '0;
      cap_pend_reg <= 1'b0;
    end else begin
      cap_pend_reg <= reference_capture_trigger_i;
      if (cap_pend_reg) offset_reg <= cap_off;
      else if (offset_wr_i) offset_reg <= offset_i;
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  // Checks sleep during reset so the unreset history cannot trip them.
  default clocking cb_dvp @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_take_to_result;
    (sample_valid_i && sample_ready_o) |-> ##[3:27] result_valid_o;
  endproperty
  a_take_to_result: assert property (p_take_to_result)
    else $error("Accepted sample produced no result in time.");

  property p_div_latency;
    div.start |-> ##24 div.done;
  endproperty
  a_div_latency: assert property (p_div_latency)
    else $error("Block mean did not finish on the expected cycle.");

  property p_slope;
    (state_reg == DVP_POST && cfg_falling_i) |=>
      ((meas_reg + $past(filt_ext)) == RW'(0));
  endproperty
  a_slope: assert property (p_slope)
    else $error("Falling slope did not negate the filtered value.");

  property p_capture_offset;
    capture_busy_o |=> (offset_o == $past(cap_off));
  endproperty
  a_capture_offset: assert property (p_capture_offset)
    else $error("Captured offset is not preset minus measured value.");

  property p_clamp_zero;
    (result_valid_o && post_neg) |=> (result_o == '0);
  endproperty
  a_clamp_zero: assert property (p_clamp_zero)
    else $error("Negative corrected result was not shown as zero.");

  property p_capture_once;
    !reference_capture_trigger_i |=> !capture_busy_o;
  endproperty
  a_capture_once: assert property (p_capture_once)
    else $error("Capture stayed pending without a new request.");

  c_avg_mean:     cover property (div.done && filt_reg == DVP_FILT_AVG);
  c_strong_block: cover property (div.done && depth_reg == DVP_DEPTH_STRONG);
  c_clamped:      cover property (result_valid_o && post_neg);
  c_capture:      cover property (capture_busy_o);

endmodule : dvp_postproc

// File: dvp_postproc_sva.sv
// Spare file: the block's checks sit beside the logic they guard.

// File: dvp_sample_src.sv
// Model of the optical front end that offers distance samples.
module dvp_sample_src
  import dvp_pkg::*;
(
  input  wire logic          clk_i,    // Processing clock.
  input  wire logic          ready_i,  // Pipeline can take a sample.
  output logic               valid_o,  // Sample offered.
  output logic [DW-1:0]      sample_o  // Raw distance.
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    valid_o = 1'b0;
    sample_o = '0;
  end

  // Offers after gap + 1 idle cycles and holds until taken at an edge, for at most 200 edges.
  // The line shows the inverse afterwards so no stale value looks valid.
  task automatic send(input logic [DW-1:0] v, input int gap, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap + 1) @(posedge clk_i);
    valid_o  <= 1'b1;
    sample_o <= v;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge clk_i);
      ok = (ready_i === 1'b1);
    end
    valid_o  <= 1'b0;
    sample_o <= ~v;
  endtask : send
endmodule : dvp_sample_src

// File: dvp_postproc_bench.sv
// Self-checking bench for the distance value post-processor.
module dvp_postproc_bench;
  import dvp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic          clk_i, rst_n_i, sample_valid_i, sample_ready_o;
  logic          cfg_wr_i, cfg_falling_i, offset_wr_i, trig;
  logic [DW-1:0] sample_i, preset_i, result_o;
  logic [CW-1:0] cfg_count_i;
  logic [1:0]    cfg_filter_i, cfg_depth_i;
  logic [OW-1:0] offset_i, offset_o;
  logic          capture_busy_o, result_valid_o, seen;
  int            eq[$], hist[$], blk[$];
  int            n_mismatch, check_count, n_put, n_res;
  int            mode, cnt, pct, off, last_meas, hold;
  logic [15:0]   rnd;

  dvp_postproc dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .sample_ready_o(sample_ready_o), .cfg_wr_i(cfg_wr_i),
    .cfg_filter_i(cfg_filter_i), .cfg_count_i(cfg_count_i),
    .cfg_depth_i(cfg_depth_i), .cfg_falling_i(cfg_falling_i),
    .offset_wr_i(offset_wr_i), .offset_i(offset_i), .preset_i(preset_i),
    .reference_capture_trigger_i(trig), .offset_o(offset_o),
    .capture_busy_o(capture_busy_o), .result_valid_o(result_valid_o),
    .result_o(result_o));

  dvp_sample_src src (.clk_i(clk_i), .ready_i(sample_ready_o),
    .valid_o(sample_valid_i), .sample_o(sample_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("results %0d checks %0d mismatches %0d", n_res, check_count,
             n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------------
  // The result word settles one cycle after the strobe.
  always @(posedge clk_i) begin
    if (seen) begin
      n_res++;
      if (eq.size() == 0)
        check(32'h1, 32'h0);
      else
        check({16'h0000, result_o}, eq[0]);
      if (eq.size() > 0)
        void'(eq.pop_front());
    end
    seen = (result_valid_o === 1'b1);
  end

  // ---------------------------------------------------------------------
  // Drivers and reference
  // ---------------------------------------------------------------------
  task automatic put(input int v);
    int m, s, t, e;
    bit ok;
    m = v;
    src.send(DW'(v), v % 3, ok);
    if (!ok) begin
      n_mismatch++;
      final_report();
    end
    hist.push_back(v);
    if (hist.size() > cnt)
      void'(hist.pop_front());
    if (mode == 1) begin
      s = 0;
      foreach (hist[i]) s += hist[i];
      m = s / hist.size();
    end else if (mode == 2) begin
      // Between blocks the last block result repeats, or the raw sample
      // before any block has been evaluated.
      blk.push_back(v);
      if (blk.size() == cnt) begin
        blk.sort();
        t = cnt * pct / 100;
        s = 0;
        for (int i = t; i < cnt - t; i++) s += blk[i];
        hold = s / (cnt - 2 * t);
        blk.delete();
      end
      if (hold >= 0)
        m = hold;
    end
    last_meas = cfg_falling_i ? -m : m;
    e = last_meas + off;
    if (e < 0)
      e = 0;
    eq.push_back(e);
    n_put++;
    for (int n = 0; n < 100 && eq.size() > 0; n++) @(posedge clk_i);
    if (eq.size() > 0) begin
      n_mismatch++;
      final_report();
    end
  endtask : put

  task automatic cfg(input int f, input int n, input int d);
    @(posedge clk_i);
    cfg_wr_i     <= 1'b1;
    cfg_filter_i <= 2'(f);
    cfg_count_i  <= CW'(n);
    cfg_depth_i  <= 2'(d);
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    mode = f;
    cnt = n;
    hist.delete();
    blk.delete();
  endtask : cfg

  task automatic set_off(input int v);
    @(posedge clk_i);
    offset_wr_i <= 1'b1;
    offset_i    <= OW'(v);
    @(posedge clk_i);
    offset_wr_i <= 1'b0;
    off = v;
    @(posedge clk_i);
    check({14'h0000, offset_o}, {14'h0000, OW'(v)});
  endtask : set_off

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {rst_n_i, cfg_wr_i, cfg_falling_i, offset_wr_i, trig, seen} = '0;
    {cfg_filter_i, cfg_depth_i, cfg_count_i, offset_i} = '0;
    preset_i = '0;
    mode = 0;
    cnt = 10;
    off = 0;
    rnd = 16'h0046;
    hold = -1;
    repeat (9) @(posedge clk_i);
    #1 check({14'h0000, offset_o}, 32'h0);
    check({13'h0000, sample_ready_o, capture_busy_o, result_valid_o,
           result_o}, 32'h0004_0000);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    put(300);
    set_off(-100);
    put(1500);
    put(50);
    set_off(1000);
    cfg_falling_i <= 1'b1;
    put(300);
    put(1200);
    cfg_falling_i <= 1'b0;
    set_off(0);
    put(300);
    @(posedge clk_i);
    trig     <= 1'b1;
    preset_i <= 16'h015E;
    @(posedge clk_i);
    trig <= 1'b0;
    #1 check(capture_busy_o, 1);
    @(posedge clk_i);
    off = 350 - last_meas;
    #1 check({14'h0000, offset_o}, {14'h0000, OW'(off)});
    repeat (3) @(posedge clk_i);
    #1 check({offset_o, capture_busy_o}, {OW'(off), 1'b0});
    put(400);
    cfg(1, 4, 0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      put(rnd[11:0]);
    end
    repeat (5) put(1000);
    for (int d = 0; d < 3; d++) begin
      cfg(2, 10, d);
      pct = 12 * (d + 1);
      for (int i = 0; i < 20; i++) begin
        rnd = lfsr(rnd);
        put(rnd[11:0]);
      end
    end
    repeat (40) @(posedge clk_i);
    check(n_res, n_put);
    final_report();
  end
endmodule : dvp_postproc_bench
